/* pkg/eprom_pv_pkg.sv */
// Purpose: constants for the EPROM program and verify port
// Assumes: 14-bit address, 8-bit code bytes, classic Wishbone slave
// Notes: select patterns are first..fifth, written as {s1,s2,s3,s4,s5}
package eprom_pv_pkg;
  localparam int ADDR_W = 14;
  localparam int DEPTH = 16384;
  localparam int ENC_DEPTH = 64;
  localparam int ENC_W = 6;
  // Mode-select patterns {first,second,third,fourth,fifth}
  localparam logic [4:0] SEL_PROG_CODE = 5'h0F;
  localparam logic [4:0] SEL_VERIFY = 5'h03;
  localparam logic [4:0] SEL_PROG_ENC = 5'h0D;
  localparam logic [4:0] SEL_LOCK_ONE = 5'h1F;
  localparam logic [4:0] SEL_LOCK_TWO = 5'h1C;
  localparam logic [4:0] SEL_LOCK_THREE = 5'h16;
  localparam logic [4:0] SEL_SIGNATURE = 5'h00;
  // Signature locations
  localparam logic [13:0] SIG_ADDR0 = 14'h0030;
  localparam logic [13:0] SIG_ADDR1 = 14'h0031;
  localparam logic [13:0] SIG_ADDR2 = 14'h0060;
  // Register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  // Field positions
  localparam int CTRL_ERASE_BIT = 0;
  localparam int STAT_LOCK_LSB = 0;
  localparam int STAT_BUSY_BIT = 3;
  localparam int STAT_MODE_LSB = 8;
  // Reset and erased values
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [2:0] LOCK_RESET = 3'h0;
  localparam logic [13:0] SWEEP_RESET = 14'h0000;
  localparam logic [13:0] SWEEP_LAST = 14'h3FFF;
  // Pin modes, one-hot
  typedef enum logic [7:0] {
    M_IDLE = 8'h01,
    M_PROG_CODE = 8'h02,
    M_VERIFY = 8'h04,
    M_PROG_ENC = 8'h08,
    M_LOCK_ONE = 8'h10,
    M_LOCK_TWO = 8'h20,
    M_LOCK_THREE = 8'h40,
    M_SIGNATURE = 8'h80
  } mode_t;
endpackage

/* src/eprom_program_verify_port.sv */
// Purpose: program and verify port of an on-chip code EPROM
// Assumes: all pins synchronous to clk_i; high-voltage level on supply_vpp_i
// Notes: bits only go from one to zero; erase sweeps the whole array
// What the document requires of the programmer and of this block
// [R1] Programmer clocks the device at 4 to 6 MHz while programming; the bench clock runs at 100 MHz.
// [R2] Address is 14 bits: low eight on low lines, upper six on high.
// [R3] Code byte travels on eight data lines, bit 0 least significant.
// [R4] Code program: selects L,H,H,H,H, high voltage, pulse stores byte.
// [R5] Verify selects L,L,L,H,H; signature read selects all low.
// [R6] Encryption and three lock bits each written by their select pattern.
// [R7] Programmer raises high voltage just around the program pulse only.
// [R8] Programmer sets address, data, selects, then high voltage, in order.
// [R9] Programmer pulses five times for code, 25 for encryption or lock.
// [R10] Programmer repeats the sequence for every location to be written.
// [R11] Device writes the data byte to the addressed location on each pulse.
// [R12] Verify returns code XNOR encryption byte chosen by six address lines.
// [R13] Lock one blocks programming; locks one and two also block verify.
// [R14] Device drives data lines only in verify or signature mode.
//
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
module eprom_program_verify_port #(
  parameter logic [7:0] SIG_BYTE0 = 8'hA5, // Arbitrary identity value
  parameter logic [7:0] SIG_BYTE1 = 8'h3C, // Arbitrary identity value
  parameter logic [7:0] SIG_BYTE2 = 8'h0F  // Arbitrary identity value
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Programmer address and data pins
  input wire logic [7:0] address_low_lines_i,
  input wire logic [5:0] address_high_lines_i,
  input wire logic [7:0] code_byte_lines_i,
  output logic [7:0] code_byte_lines_o,
  output logic code_byte_lines_oe_n_o,
  // Programmer control pins
  input wire logic reset_pin_i,
  input wire logic fetch_strobe_n_i,
  input wire logic program_pulse_n_i,
  input wire logic supply_enable_i,
  input wire logic supply_vpp_i,
  input wire logic first_select_i,
  input wire logic second_select_i,
  input wire logic third_select_i,
  input wire logic fourth_select_i,
  input wire logic fifth_select_i
);
  logic [7:0] mem [eprom_pv_pkg::DEPTH];
  logic [7:0] enc [eprom_pv_pkg::ENC_DEPTH];
  logic [2:0] lock;
  logic prog_q;
  logic erasing;
  logic [13:0] sweep;
  eprom_pv_pkg::mode_t mode;

  // Address, selects and mode decode
  wire [13:0] addr = {address_high_lines_i, address_low_lines_i}; // see [R2]
  wire [4:0] sel = {first_select_i, second_select_i, third_select_i,
                    fourth_select_i, fifth_select_i};
  wire pins_ok = reset_pin_i & ~fetch_strobe_n_i;
  wire pulse_fall = prog_q & ~program_pulse_n_i;
  wire prog_ok = pins_ok & supply_vpp_i & pulse_fall & ~erasing;
  wire read_ok = pins_ok & program_pulse_n_i & supply_enable_i
                 & ~supply_vpp_i;
  wire [7:0] mem_rd = mem[addr];
  wire [7:0] enc_rd = enc[addr[eprom_pv_pkg::ENC_W-1:0]]; // see [R12]

  // One-hot mode from the select pattern
  always_comb begin
    unique case (sel)
      eprom_pv_pkg::SEL_PROG_CODE: mode = eprom_pv_pkg::M_PROG_CODE;
      eprom_pv_pkg::SEL_VERIFY: mode = eprom_pv_pkg::M_VERIFY;
      eprom_pv_pkg::SEL_PROG_ENC: mode = eprom_pv_pkg::M_PROG_ENC;
      eprom_pv_pkg::SEL_LOCK_ONE: mode = eprom_pv_pkg::M_LOCK_ONE;
      eprom_pv_pkg::SEL_LOCK_TWO: mode = eprom_pv_pkg::M_LOCK_TWO;
      eprom_pv_pkg::SEL_LOCK_THREE: mode = eprom_pv_pkg::M_LOCK_THREE;
      eprom_pv_pkg::SEL_SIGNATURE: mode = eprom_pv_pkg::M_SIGNATURE;
      default: mode = eprom_pv_pkg::M_IDLE;
    endcase
  end

  // Write strobes per target
  wire wr_code = prog_ok & (mode == eprom_pv_pkg::M_PROG_CODE)
                 & ~lock[0]; // see [R4] see [R13]
  wire wr_enc = prog_ok & (mode == eprom_pv_pkg::M_PROG_ENC)
                & ~lock[0]; // see [R6] see [R13]
  wire is_verify = read_ok & (mode == eprom_pv_pkg::M_VERIFY); // see [R5]
  wire is_sig = read_ok & (mode == eprom_pv_pkg::M_SIGNATURE); // see [R5]
  wire verify_locked = lock[0] & lock[1];

  // Byte returned on the data lines
  wire [7:0] sig_byte = (addr == eprom_pv_pkg::SIG_ADDR0) ? SIG_BYTE0 :
                        (addr == eprom_pv_pkg::SIG_ADDR1) ? SIG_BYTE1 :
                        (addr == eprom_pv_pkg::SIG_ADDR2) ? SIG_BYTE2 :
                        eprom_pv_pkg::ERASED_BYTE;
  wire [7:0] ver_byte = verify_locked ? eprom_pv_pkg::ERASED_BYTE :
                        ~(mem_rd ^ enc_rd); // see [R12] see [R13]
  wire [7:0] next_out = is_sig ? sig_byte : ver_byte;

  // Data lines driven only in a read mode
  assign code_byte_lines_oe_n_o = ~(is_verify | is_sig); // see [R14]

  // Wishbone decode
  wire bus_req = cyc_i & stb_i & ~ack_o;
  wire ctrl_hit = adr_i == eprom_pv_pkg::REG_CTRL;
  wire stat_hit = adr_i == eprom_pv_pkg::REG_STATUS;
  wire erase_go = bus_req & we_i & ctrl_hit & sel_i[0]
                  & dat_i[eprom_pv_pkg::CTRL_ERASE_BIT] & ~erasing;
  wire [31:0] stat_word = {16'h0000, mode, 4'h0, erasing, lock};
  wire [31:0] next_dat = stat_hit ? stat_word :
                         ctrl_hit ? {31'h00000000, erasing} : 32'h00000000;

  // Program pulse edge, output byte, bus answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prog_q <= 1'b1;
      code_byte_lines_o <= eprom_pv_pkg::ERASED_BYTE;
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      prog_q <= program_pulse_n_i;
      code_byte_lines_o <= next_out; // see [R3]
      ack_o <= bus_req;
      dat_o <= bus_req ? next_dat : 32'h00000000;
    end
  end

  // Erase start and sweep counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      erasing <= 1'b0;
      sweep <= eprom_pv_pkg::SWEEP_RESET;
    end else if (erase_go) begin
      erasing <= 1'b1;
      sweep <= eprom_pv_pkg::SWEEP_RESET;
    end else if (erasing) begin
      erasing <= sweep != eprom_pv_pkg::SWEEP_LAST;
      sweep <= sweep + 14'h0001;
    end
  end

  // Lock bits survive reset only as erased state; pulse programs them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock <= eprom_pv_pkg::LOCK_RESET;
    end else if (erasing) begin
      lock <= eprom_pv_pkg::LOCK_RESET;
    end else if (prog_ok) begin
      if (mode == eprom_pv_pkg::M_LOCK_ONE) lock[0] <= 1'b1; // see [R6]
      if (mode == eprom_pv_pkg::M_LOCK_TWO) lock[1] <= 1'b1;
      if (mode == eprom_pv_pkg::M_LOCK_THREE) lock[2] <= 1'b1;
    end
  end

  // Array writes clear bits only; erase restores ones
  always_ff @(posedge clk_i) begin
    if (erasing) begin
      mem[sweep] <= eprom_pv_pkg::ERASED_BYTE;
      enc[sweep[eprom_pv_pkg::ENC_W-1:0]] <= eprom_pv_pkg::ERASED_BYTE;
    end else if (wr_code) begin
      mem[addr] <= mem_rd & code_byte_lines_i; // see [R11]
    end else if (wr_enc) begin
      enc[addr[eprom_pv_pkg::ENC_W-1:0]] <= enc_rd & code_byte_lines_i;
    end
  end

  // Checks, all on the one clock and off during reset
  default clocking chk_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  AST_ADDR_JOIN: assert property ( // see [R2]
    is_verify && !verify_locked |=> code_byte_lines_o ==
    $past(~(mem[{address_high_lines_i, address_low_lines_i}] ^
    enc[address_low_lines_i[eprom_pv_pkg::ENC_W-1:0]])))
    else $error("address lines joined wrongly");
  AST_OE_READ: assert property ( // see [R14]
    (read_ok && (sel == eprom_pv_pkg::SEL_VERIFY ||
     sel == eprom_pv_pkg::SEL_SIGNATURE)) == !code_byte_lines_oe_n_o)
    else $error("data lines enable wrong");
  AST_CODE_WRITE: assert property ( // see [R11]
    wr_code |=> mem[$past(addr)] ==
    ($past(mem_rd) & $past(code_byte_lines_i)))
    else $error("code byte not stored");
  AST_ENC_WRITE: assert property ( // see [R6]
    wr_enc |=> enc[$past(addr[eprom_pv_pkg::ENC_W-1:0])] ==
    ($past(enc_rd) & $past(code_byte_lines_i)))
    else $error("encryption byte not stored");
  AST_NO_VPP: assert property ( // see [R4]
    pulse_fall && !supply_vpp_i && !erasing |=>
    mem[$past(addr)] == $past(mem_rd))
    else $error("write without high voltage");
  AST_LOCK_PROG: assert property ( // see [R13]
    lock[0] && !erasing |=> mem[$past(addr)] == $past(mem_rd))
    else $error("locked array changed");
  AST_LOCK_ONE: assert property ( // see [R6]
    prog_ok && sel == eprom_pv_pkg::SEL_LOCK_ONE |=> lock[0] ##1 lock[0])
    else $error("lock one not set");
  AST_VERIFY: assert property ( // see [R12]
    is_verify && !verify_locked |=>
    code_byte_lines_o == ~($past(mem_rd) ^ $past(enc_rd)))
    else $error("verify byte wrong");
  AST_VERIFY_LOCK: assert property ( // see [R13]
    is_verify && verify_locked |=> code_byte_lines_o == 8'hFF)
    else $error("locked verify leaked");
  AST_SIG: assert property ( // see [R5]
    is_sig && addr == eprom_pv_pkg::SIG_ADDR1 |=>
    code_byte_lines_o == SIG_BYTE1)
    else $error("signature byte wrong");
  AST_ACK: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("bus answer timing wrong");
  // Main scenarios reached
  COV_WRITE: cover property (wr_code);
  COV_VERIFY: cover property (is_verify && !verify_locked);
  COV_LOCKED: cover property (is_verify && verify_locked);
  COV_SIG: cover property (is_sig);
  COV_ERASE: cover property (erasing ##1 !erasing);
endmodule
`default_nettype wire

/* tb/prog_model.sv */
// Purpose: external programmer driving the port pins
// Assumes: pins change just after a rising edge
// Notes: released data lines show the inverse of the last byte
`timescale 1ns/1ns
`default_nettype none
module prog_model (
  // Clock and device side
  input wire logic clk_i,
  input wire logic [7:0] dev_byte_i,
  input wire logic dev_oe_n_i,
  // Pin levels
  output logic [13:0] addr_o,
  output logic [7:0] lines_o,
  output logic [4:0] sel_o,
  output logic pulse_n_o,
  output logic vpp_o
);
  logic [7:0] drv = 8'hFF;
  logic own = 1'b0;
  // Level raised on the supply pin by the next program sequence
  logic hv = 1'b1;
  initial begin
    addr_o = 14'h0000;
    sel_o = 5'h00;
    pulse_n_o = 1'b1;
    vpp_o = 1'b0;
  end
  // Wire level from both parties
  assign lines_o = !dev_oe_n_i ? dev_byte_i : own ? drv : ~drv;
  // One location: address, data, selects, high voltage, pulses
  task automatic prog(input logic [4:0] s, input logic [13:0] ad,
                      input logic [7:0] d, input int n);
    @(posedge clk_i);
    addr_o <= ad;
    @(posedge clk_i);
    drv <= d;
    own <= 1'b1;
    @(posedge clk_i);
    sel_o <= s;
    @(posedge clk_i);
    vpp_o <= hv;
    repeat (n) begin
      @(posedge clk_i);
      pulse_n_o <= 1'b0;
      @(posedge clk_i);
      pulse_n_o <= 1'b1;
    end
    @(posedge clk_i);
    vpp_o <= 1'b0;
    own <= 1'b0;
  endtask
  // Verify or signature read of one location
  task automatic rd(input logic [4:0] s, input logic [13:0] ad,
                    output logic [7:0] q);
    @(posedge clk_i);
    addr_o <= ad;
    sel_o <= s;
    repeat (3) @(posedge clk_i);
    #1 q = lines_o;
  endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// Purpose: self-checking bench for the EPROM program and verify port
// Assumes: an erase runs before any programming
// Notes: pins come from prog_model except reset, fetch strobe and supply enable, registers over Wishbone
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) check_count++; if ((a) !== (b)) begin bad_count++; \
  $display("Error %0t: got %h want %h", $time, a, b); end
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, oe_n, pulse_n, vpp;
  logic [3:0] adr = 4'h0, bsel = 4'hF;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [7:0] dev_byte, lines, b;
  logic [13:0] pa;
  logic [4:0] sel;
  logic pin_rst = 1'b1, fetch_n = 1'b0, sup_en = 1'b1;
  int bad_count = 0, check_count = 0, cycles = 0;
  // Clock and hang guard
  always #5 clk = ~clk; // Stands in for the oscillator
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      print_verdict();
    end
  end
  eprom_program_verify_port #(.SIG_BYTE0(8'hA5), .SIG_BYTE1(8'h3C),
    .SIG_BYTE2(8'h0F)) uut (
    .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(bsel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .address_low_lines_i(pa[7:0]), .address_high_lines_i(pa[13:8]),
    .code_byte_lines_i(lines), .code_byte_lines_o(dev_byte),
    .code_byte_lines_oe_n_o(oe_n), .reset_pin_i(pin_rst),
    .fetch_strobe_n_i(fetch_n), .program_pulse_n_i(pulse_n),
    .supply_enable_i(sup_en), .supply_vpp_i(vpp), .first_select_i(sel[4]),
    .second_select_i(sel[3]), .third_select_i(sel[2]),
    .fourth_select_i(sel[1]), .fifth_select_i(sel[0]));
  prog_model pm (.clk_i(clk), .dev_byte_i(dev_byte), .dev_oe_n_i(oe_n),
    .addr_o(pa), .lines_o(lines), .sel_o(sel), .pulse_n_o(pulse_n),
    .vpp_o(vpp));
  // Classic Wishbone single cycle
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Whole-array erase, polled until idle
  task automatic erase();
    wb(1'b1, eprom_pv_pkg::REG_CTRL, 32'h1);
    do wb(1'b0, eprom_pv_pkg::REG_CTRL, 32'h0); while (q[0] !== 1'b0);
  endtask
  // Code bytes at a mid address and the top of the range, pin qualifiers, no-voltage pulse
  task automatic t_code();
    wb(1'b1, 4'h8, 32'hFFFF_FFFF);
    wb(1'b0, 4'h8, 32'h0);
    `CHK(q, 32'h0)
    erase();
    pm.hv = 1'b0;
    pm.prog(eprom_pv_pkg::SEL_PROG_CODE, 14'h0100, 8'h00, 5);
    pm.hv = 1'b1;
    pm.rd(eprom_pv_pkg::SEL_VERIFY, 14'h0100, b);
    `CHK(b, 8'hFF)
    pm.prog(eprom_pv_pkg::SEL_PROG_CODE, 14'h1234, 8'h5A, 5);
    `CHK(oe_n, 1'b1)
    pm.prog(eprom_pv_pkg::SEL_PROG_CODE, 14'h3FFF, 8'hC3, 5);
    pm.rd(eprom_pv_pkg::SEL_VERIFY, 14'h1234, b);
    `CHK(b, 8'h5A)
    `CHK(oe_n, 1'b0)
    // Fetch strobe, reset pin and supply enable each taken away in turn release the data lines
    @(posedge clk);
    fetch_n <= 1'b1;
    @(posedge clk);
    `CHK(oe_n, 1'b1)
    fetch_n <= 1'b0;
    pin_rst <= 1'b0;
    @(posedge clk);
    `CHK(oe_n, 1'b1)
    pin_rst <= 1'b1;
    sup_en <= 1'b0;
    @(posedge clk);
    `CHK(oe_n, 1'b1)
    sup_en <= 1'b1;
    @(posedge clk);
    `CHK(oe_n, 1'b0)
    pm.rd(eprom_pv_pkg::SEL_VERIFY, 14'h3FFF, b);
    `CHK(b, 8'hC3)
    pm.rd(eprom_pv_pkg::SEL_VERIFY, 14'h2234, b);
    `CHK(b, 8'hFF)
  endtask
  // Encryption byte and signature table
  task automatic t_enc_sig();
    logic [13:0] sa[4] = '{14'h0030, 14'h0031, 14'h0060, 14'h0032};
    logic [7:0] sv[4] = '{8'hA5, 8'h3C, 8'h0F, 8'hFF};
    pm.prog(eprom_pv_pkg::SEL_PROG_ENC, 14'h0034, 8'h0F, 25);
    pm.rd(eprom_pv_pkg::SEL_VERIFY, 14'h1234, b);
    `CHK(b, 8'hAA)
    for (int i = 0; i < 4; i++) begin
      pm.rd(eprom_pv_pkg::SEL_SIGNATURE, sa[i], b);
      `CHK(b, sv[i])
    end
    wb(1'b0, eprom_pv_pkg::REG_STATUS, 32'h0);
    `CHK(q[15:8], eprom_pv_pkg::M_SIGNATURE)
  endtask
  // Lock levels, erase restores, a mid-run reset clears a lock
  task automatic t_lock();
    pm.prog(eprom_pv_pkg::SEL_LOCK_ONE, 14'h0000, 8'hFF, 25);
    wb(1'b0, eprom_pv_pkg::REG_STATUS, 32'h0);
    `CHK(q[2:0], 3'h1)
    pm.prog(eprom_pv_pkg::SEL_PROG_CODE, 14'h1234, 8'h00, 5);
    pm.rd(eprom_pv_pkg::SEL_VERIFY, 14'h1234, b);
    `CHK(b, 8'hAA)
    pm.prog(eprom_pv_pkg::SEL_LOCK_TWO, 14'h0000, 8'hFF, 25);
    pm.rd(eprom_pv_pkg::SEL_VERIFY, 14'h1234, b);
    `CHK(b, 8'hFF)
    pm.prog(eprom_pv_pkg::SEL_LOCK_THREE, 14'h0000, 8'hFF, 25);
    wb(1'b0, eprom_pv_pkg::REG_STATUS, 32'h0);
    `CHK(q[2:0], 3'h7)
    erase();
    wb(1'b0, eprom_pv_pkg::REG_STATUS, 32'h0);
    `CHK(q[3:0], 4'h0)
    pm.prog(eprom_pv_pkg::SEL_LOCK_ONE, 14'h0000, 8'hFF, 25);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, eprom_pv_pkg::REG_STATUS, 32'h0);
    `CHK(q[2:0], 3'h0)
  endtask
  // Verdict and end of run
  task automatic print_verdict();
    if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_code();
    t_enc_sig();
    t_lock();
    print_verdict();
  end
endmodule
`default_nettype wire
